// ==== rtl/sar_pkg.sv ====
package sar_pkg;

    // system clock
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_NS = 100;

    // bit clock made here: half period in system cycles (800 ns period)
    localparam int BCLK_HALF_CYCLES = 4;

    // back-end error pulse, least width rounded up to whole cycles
    localparam int ERR_PULSE_NS = 350;
    localparam int ERR_PULSE_CYCLES = (ERR_PULSE_NS + CLK_NS - 1) / CLK_NS;

    // device holds its bridge outputs low this long after an error
    localparam int ERR_HOLD_MS = 300;
    localparam int ERR_HOLD_CYCLES = ERR_HOLD_MS * (CLK_HZ / 1000);

    // format straps settle this long before the device reset is released
    localparam int FMT_SETUP_US = 100;
    localparam int FMT_SETUP_CYCLES = FMT_SETUP_US * (CLK_HZ / 1_000_000);

    // register word addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_ERR = 4'h1;
    localparam logic [3:0] ADDR_STAT = 4'h2;
    localparam logic [3:0] ADDR_MAIN_L = 4'h4;
    localparam logic [3:0] ADDR_MAIN_R = 4'h5;
    localparam logic [3:0] ADDR_SUB_L = 4'h6;
    localparam logic [3:0] ADDR_SUB_R = 4'h7;

    // control fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_RATIO_LSB = 1;
    localparam int CTRL_LONG_BIT = 3;
    localparam int CTRL_FMT_LSB = 4;
    localparam int ERR_FIRE_BIT = 0;

    // status fields
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_ERR_BIT = 1;
    localparam int STAT_HOLD_BIT = 2;
    localparam int STAT_FRAMES_LSB = 16;

    // bit clocks per frame: 32, 48, 64 sample periods
    localparam logic [1:0] RATIO_32 = 2'h0;
    localparam logic [1:0] RATIO_48 = 2'h1;
    localparam logic [1:0] RATIO_64 = 2'h2;
    localparam logic [1:0] RATIO_RESET = RATIO_64;

    // format strap codes (pin 2, pin 1, pin 0)
    localparam logic [2:0] FMT_RJ16 = 3'h0;
    localparam logic [2:0] FMT_RJ18 = 3'h1;
    localparam logic [2:0] FMT_RJ20 = 3'h2;
    localparam logic [2:0] FMT_RJ24 = 3'h3;
    localparam logic [2:0] FMT_I2S = 3'h4;
    localparam logic [2:0] FMT_LJ = 3'h5;
    localparam logic [2:0] FMT_LAST_LEGAL = FMT_LJ;
    localparam logic [2:0] FMT_RESET = FMT_RJ16;

    localparam logic [5:0] WLEN_16 = 6'h10;
    localparam logic [5:0] WLEN_18 = 6'h12;
    localparam logic [5:0] WLEN_20 = 6'h14;
    localparam logic [5:0] WLEN_24 = 6'h18;

    typedef enum logic [1:0] {
        SAR_RIGHT_JUST,
        SAR_I2S,
        SAR_LEFT_JUST
    } sar_framing_type;

    typedef enum logic [1:0] {
        ERR_IDLE,
        ERR_PULSE,
        ERR_HOLD
    } sar_err_state_type;

    // pins toward the device's serial port
    typedef struct packed {
        logic bclk;
        logic lrclk;
        logic main_serial_input;
        logic sub_serial_input;
    } sar_link_type;

endpackage

// ==== rtl/sar_bit_clock.sv ====
`timescale 1ns/1ps
module sar_bit_clock #(
    parameter int HALF_CYCLES = sar_pkg::BCLK_HALF_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [5:0] i_half_bits,
    output logic o_bclk,
    output logic o_fall,
    output logic o_frame_start,
    output logic [5:0] o_slot,
    output logic o_right
);

    logic [7:0] div_q;
    logic tick;
    logic wrap;

    assign tick = (div_q == 8'(HALF_CYCLES - 1));
    // a slot index at or beyond the last bit also wraps, so a ratio change is harmless
    assign wrap = (o_slot >= i_half_bits - 6'h01);

    always_ff @(posedge i_clk)
    begin
        if (i_rst || tick)
            div_q <= 8'h00;
        else
            div_q <= div_q + 8'h01;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_bclk <= 1'b0;
        else if (tick)
            o_bclk <= ~o_bclk;
    end

    // slot advances with the falling bit clock edge; the device samples on the rising one
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_slot <= 6'h3F;
            o_right <= 1'b1;
        end
        else if (tick && o_bclk)
        begin
            o_slot <= wrap ? 6'h00 : o_slot + 6'h01;
            if (wrap)
                o_right <= ~o_right;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_fall <= 1'b0;
            o_frame_start <= 1'b0;
        end
        else
        begin
            o_fall <= tick && o_bclk;
            o_frame_start <= tick && o_bclk && wrap && o_right;
        end
    end

endmodule

// ==== rtl/sar_host.sv ====
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - I2S: frame clock low carries left word, high carries right word.
// - I2S: first data bit one bit clock after frame clock changes.
// - Words go out MSB first; device samples each bit on rising bit clock.
// - Justified framings: frame clock high is left slot, low is right.
// - Left-justified: MSB in same bit period as the frame clock toggle.
// - Right-justified: LSB on last bit before toggle; 24-bit starts 8 bits earlier than 16-bit. At ratio 32 only the top 16 bits of longer words are sent.
// - Both data lines share one bit clock, frame clock and framing.
// - Format pins stay steady while the device reset is released.
// - The two reserved format codes are never driven.
// - Error pulse lasts at least 350 ns; outputs fall about 350 ns later.
// - Between 32 and 64 rising bit clocks in each frame.
module sar_host #(
    parameter int RECOVER_CYCLES = sar_pkg::ERR_HOLD_CYCLES,
    parameter int BCLK_HALF = sar_pkg::BCLK_HALF_CYCLES
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic [3:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    output sar_pkg::sar_link_type O_LINK,
    output logic [2:0] O_FMT_SEL,
    output logic O_DEV_RESET_N,
    output logic O_BACK_END_ERROR_N
);

    localparam int HOLD_W = $clog2(RECOVER_CYCLES + 1);
    localparam int SETUP_W = $clog2(sar_pkg::FMT_SETUP_CYCLES + 1);

    function automatic logic [5:0] half_of(input logic [1:0] ratio);
        unique case (ratio)
            sar_pkg::RATIO_32: half_of = 6'h10;
            sar_pkg::RATIO_48: half_of = 6'h18;
            default: half_of = 6'h20;
        endcase
    endfunction

    function automatic sar_pkg::sar_framing_type framing_of(input logic [2:0] code);
        if (code == sar_pkg::FMT_I2S)
            framing_of = sar_pkg::SAR_I2S;
        else if (code == sar_pkg::FMT_LJ)
            framing_of = sar_pkg::SAR_LEFT_JUST;
        else
            framing_of = sar_pkg::SAR_RIGHT_JUST;
    endfunction

    // sample words are stored left-aligned, so short words use the upper bits
    function automatic logic bit_of(input logic [23:0] w, input logic [5:0] k,
                                    input logic [5:0] st, input logic [5:0] wl);
        logic [5:0] p;
        p = k - st;
        bit_of = 1'b0;
        if (k >= st && p < wl)
            bit_of = w[5'(6'h17 - p)];
    endfunction

    logic run_q;
    logic [1:0] ratio_q;
    logic long_q;
    logic [2:0] fmt_q;
    logic [23:0] smp_q [4];
    logic [23:0] sh_q [4];
    logic [SETUP_W-1:0] setup_q;
    logic [HOLD_W-1:0] err_cnt_q;
    sar_pkg::sar_err_state_type err_state_q;
    logic [15:0] frames_q;
    logic lrclk_q;
    logic main_sd_q;
    logic sub_sd_q;
    logic bclk;
    logic fall;
    logic frame_start;
    logic [5:0] slot;
    logic right;
    logic [5:0] half;
    logic [5:0] wlen;
    logic [5:0] start;
    sar_pkg::sar_framing_type framing;
    logic [23:0] main_w;
    logic [23:0] sub_w;
    logic wr_ctrl;
    logic fire;
    logic wr_smp;
    logic [5:0] half_q;
    logic long_f_q;
    logic long_w;

    assign wr_ctrl = I_WR && (I_ADDR == sar_pkg::ADDR_CTRL);
    assign fire = I_WR && (I_ADDR == sar_pkg::ADDR_ERR) && I_WDATA[sar_pkg::ERR_FIRE_BIT];
    assign wr_smp = I_WR && (I_ADDR[3:2] == sar_pkg::ADDR_MAIN_L[3:2]);
    // the frame start edge already uses the new ratio and word length, so slot 0
    // of the frame and every later slot agree on them
    assign half = frame_start ? half_of(ratio_q) : half_q;
    assign long_w = frame_start ? long_q : long_f_q;
    // framing follows the pins the device actually latched
    assign framing = framing_of(O_FMT_SEL);

    always_comb
    begin
        unique case (O_FMT_SEL)
            sar_pkg::FMT_RJ16: wlen = sar_pkg::WLEN_16;
            sar_pkg::FMT_RJ18: wlen = sar_pkg::WLEN_18;
            sar_pkg::FMT_RJ20: wlen = sar_pkg::WLEN_20;
            sar_pkg::FMT_RJ24: wlen = sar_pkg::WLEN_24;
            default: wlen = long_w ? sar_pkg::WLEN_24 : sar_pkg::WLEN_16;
        endcase
    end

    always_comb
    begin
        unique case (framing)
            sar_pkg::SAR_I2S: start = 6'h01;
            sar_pkg::SAR_LEFT_JUST: start = 6'h00;
            // a word wider than the slot loses its low bits rather than its MSB
            sar_pkg::SAR_RIGHT_JUST: start = (half > wlen) ? half - wlen : 6'h00;
            default: start = 6'h00;
        endcase
    end

    // the first bit of a frame comes from the live registers, later ones from the copy
    assign main_w = right ? sh_q[1] : (frame_start ? smp_q[0] : sh_q[0]);
    assign sub_w = right ? sh_q[3] : (frame_start ? smp_q[2] : sh_q[2]);

    sar_bit_clock #(
        .HALF_CYCLES(BCLK_HALF)
    ) u_bit_clock (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_half_bits(half),
        .o_bclk(bclk),
        .o_fall(fall),
        .o_frame_start(frame_start),
        .o_slot(slot),
        .o_right(right)
    );

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            run_q <= 1'b0;
            ratio_q <= sar_pkg::RATIO_RESET;
            long_q <= 1'b0;
            fmt_q <= sar_pkg::FMT_RESET;
        end
        else if (wr_ctrl)
        begin
            run_q <= I_WDATA[sar_pkg::CTRL_RUN_BIT];
            long_q <= I_WDATA[sar_pkg::CTRL_LONG_BIT];
            if (I_WDATA[sar_pkg::CTRL_RATIO_LSB +: 2] != 2'h3)
                ratio_q <= I_WDATA[sar_pkg::CTRL_RATIO_LSB +: 2];
            if (I_WDATA[sar_pkg::CTRL_FMT_LSB +: 3] <= sar_pkg::FMT_LAST_LEGAL)
                fmt_q <= I_WDATA[sar_pkg::CTRL_FMT_LSB +: 3];
        end
    end

    // a sample write lands in the next frame; the shadow copy keeps a frame whole
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            for (int i = 0; i < 4; i++)
                smp_q[i] <= 24'h000000;
        end
        else if (wr_smp)
            smp_q[I_ADDR[1:0]] <= I_WDATA[23:0];
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            for (int i = 0; i < 4; i++)
                sh_q[i] <= 24'h000000;
        end
        else if (frame_start)
        begin
            for (int i = 0; i < 4; i++)
                sh_q[i] <= smp_q[i];
        end
    end

    // ratio and word length move only at a frame boundary: a mid-frame change
    // would otherwise give a frame other than 32, 48 or 64 bit clocks while the device runs
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            half_q <= half_of(sar_pkg::RATIO_RESET);
            long_f_q <= 1'b0;
        end
        else if (frame_start)
        begin
            half_q <= half_of(ratio_q);
            long_f_q <= long_q;
        end
    end

    // straps move only while the device is held in reset
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
            O_FMT_SEL <= sar_pkg::FMT_RESET;
        else if (!O_DEV_RESET_N)
            O_FMT_SEL <= fmt_q;
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST || !run_q || O_FMT_SEL != fmt_q)
            setup_q <= '0;
        else if (setup_q != SETUP_W'(sar_pkg::FMT_SETUP_CYCLES))
            setup_q <= setup_q + SETUP_W'(1);
    end

    // release only after the straps have been steady for the setup time
    always_ff @(posedge I_CLK)
    begin
        if (I_RST || !run_q)
            O_DEV_RESET_N <= 1'b0;
        else if (setup_q == SETUP_W'(sar_pkg::FMT_SETUP_CYCLES) && O_FMT_SEL == fmt_q)
            O_DEV_RESET_N <= 1'b1;
    end

    // a second error request during pulse or hold is dropped: the device is already down
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            err_state_q <= sar_pkg::ERR_IDLE;
            err_cnt_q <= '0;
            O_BACK_END_ERROR_N <= 1'b1;
        end
        else
        begin
            unique case (err_state_q)
                sar_pkg::ERR_IDLE:
                begin
                    if (fire)
                    begin
                        err_state_q <= sar_pkg::ERR_PULSE;
                        err_cnt_q <= '0;
                        O_BACK_END_ERROR_N <= 1'b0;
                    end
                end
                sar_pkg::ERR_PULSE:
                begin
                    err_cnt_q <= err_cnt_q + HOLD_W'(1);
                    if (err_cnt_q == HOLD_W'(sar_pkg::ERR_PULSE_CYCLES - 1))
                    begin
                        err_state_q <= sar_pkg::ERR_HOLD;
                        err_cnt_q <= '0;
                        O_BACK_END_ERROR_N <= 1'b1;
                    end
                end
                sar_pkg::ERR_HOLD:
                begin
                    err_cnt_q <= err_cnt_q + HOLD_W'(1);
                    if (err_cnt_q == HOLD_W'(RECOVER_CYCLES - 1))
                        err_state_q <= sar_pkg::ERR_IDLE;
                end
                default: err_state_q <= sar_pkg::ERR_IDLE;
            endcase
        end
    end

    // data and frame clock change one cycle after the falling bit clock,
    // leaving three cycles of setup before the device samples on the rise
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            lrclk_q <= 1'b0;
            main_sd_q <= 1'b0;
            sub_sd_q <= 1'b0;
        end
        else if (fall)
        begin
            lrclk_q <= (framing == sar_pkg::SAR_I2S) ? right : ~right;
            main_sd_q <= bit_of(main_w, slot, start, wlen);
            sub_sd_q <= bit_of(sub_w, slot, start, wlen);
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
            frames_q <= 16'h0000;
        else if (frame_start)
            frames_q <= frames_q + 16'h0001;
    end

    // read data stand from the cycle after the strobe until the next read
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
            O_RDATA <= 32'h00000000;
        else if (I_RD)
        begin
            O_RDATA <= 32'h00000000;
            unique case (I_ADDR)
                sar_pkg::ADDR_CTRL:
                begin
                    O_RDATA[sar_pkg::CTRL_RUN_BIT] <= run_q;
                    O_RDATA[sar_pkg::CTRL_RATIO_LSB +: 2] <= ratio_q;
                    O_RDATA[sar_pkg::CTRL_LONG_BIT] <= long_q;
                    O_RDATA[sar_pkg::CTRL_FMT_LSB +: 3] <= fmt_q;
                end
                sar_pkg::ADDR_STAT:
                begin
                    O_RDATA[sar_pkg::STAT_RUN_BIT] <= O_DEV_RESET_N;
                    O_RDATA[sar_pkg::STAT_ERR_BIT] <= err_state_q == sar_pkg::ERR_PULSE;
                    O_RDATA[sar_pkg::STAT_HOLD_BIT] <= err_state_q == sar_pkg::ERR_HOLD;
                    O_RDATA[sar_pkg::STAT_FRAMES_LSB +: 16] <= frames_q;
                end
                sar_pkg::ADDR_MAIN_L, sar_pkg::ADDR_MAIN_R,
                sar_pkg::ADDR_SUB_L, sar_pkg::ADDR_SUB_R:
                    O_RDATA[23:0] <= smp_q[I_ADDR[1:0]];
                default: O_RDATA <= 32'h00000000;
            endcase
        end
    end

    assign O_LINK = '{bclk: bclk, lrclk: lrclk_q,
                      main_serial_input: main_sd_q, sub_serial_input: sub_sd_q};

endmodule

// ==== test/sar_host_sva.sv ====
`timescale 1ns/1ps
module sar_host_sva #(
    parameter int RECOVER_CYCLES = sar_pkg::ERR_HOLD_CYCLES,
    parameter int BCLK_HALF = sar_pkg::BCLK_HALF_CYCLES
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic [3:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [31:0] O_RDATA,
    input wire sar_pkg::sar_link_type O_LINK,
    input wire logic [2:0] O_FMT_SEL,
    input wire logic O_DEV_RESET_N,
    input wire logic O_BACK_END_ERROR_N
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    logic bclk_q, lr_q, framed_q;
    logic [6:0] rises_q;
    wire lr_rise = O_LINK.lrclk && !lr_q;
    // a frame is judged only when the device was out of reset for all of it
    always_ff @(posedge I_CLK)
    begin
        bclk_q <= O_LINK.bclk;
        lr_q <= O_LINK.lrclk;
        framed_q <= !I_RST && O_DEV_RESET_N && (framed_q || lr_rise);
        if (I_RST || lr_rise)
            rises_q <= 7'h00;
        else if (O_LINK.bclk && !bclk_q)
            rises_q <= rises_q + 7'h01;
    end
    chk_fmt_frozen: assert property (
        O_DEV_RESET_N && $past(O_DEV_RESET_N) |-> $stable(O_FMT_SEL))
        else $error("format pins moved while device runs");
    chk_fmt_legal: assert property (
        O_FMT_SEL <= sar_pkg::FMT_LAST_LEGAL)
        else $error("reserved format code driven");
    chk_err_width: assert property (
        $fell(O_BACK_END_ERROR_N) |-> !O_BACK_END_ERROR_N [*4] ##1 O_BACK_END_ERROR_N)
        else $error("error pulse not four cycles");
    chk_err_cause: assert property (
        $fell(O_BACK_END_ERROR_N) |-> $past(I_WR && I_ADDR == sar_pkg::ADDR_ERR && I_WDATA[0]))
        else $error("error pulse without a fire write");
    // bit clock high time fixed at the default half period of 4 cycles
    chk_bclk_high: assert property (
        $rose(O_LINK.bclk) |-> O_LINK.bclk [*4] ##1 !O_LINK.bclk)
        else $error("bit clock high time wrong");
    chk_lr_timing: assert property (
        $changed(O_LINK.lrclk) |-> $past(O_LINK.bclk, 2) && !$past(O_LINK.bclk))
        else $error("frame clock moved away from bit clock fall");
    chk_data_timing: assert property (
        $changed(O_LINK.main_serial_input) || $changed(O_LINK.sub_serial_input)
        |-> $past(O_LINK.bclk, 2) && !$past(O_LINK.bclk))
        else $error("data moved away from bit clock fall");
    chk_frame_len: assert property (
        lr_rise && framed_q |-> rises_q inside {7'h20, 7'h30, 7'h40})
        else $error("bit clocks per frame not 32, 48 or 64");
endmodule

// ==== test/sar_dev_model.sv ====
`timescale 1ns/1ps
module sar_dev_model (
    input wire sar_pkg::sar_link_type i_link,
    input wire logic [2:0] i_fmt_sel,
    input wire logic i_dev_reset_n,
    input wire logic i_back_end_error_n,
    input wire logic i_arm,
    output logic o_done,
    output logic [23:0] o_main_l,
    output logic [23:0] o_main_r,
    output logic [23:0] o_sub_l,
    output logic [6:0] o_bits,
    output logic [7:0] o_err_cnt
);
    logic [2:0] fmt_q;
    logic [63:0] main_b, sub_b;
    logic lr_last, got_left;
    int n, n_left;
    realtime t_fall;
    initial
    begin
        {o_done, lr_last, got_left} = 3'h0;
        n = 0;
        o_err_cnt = 8'h00;
        t_fall = 0.0;
    end
    always @(posedge i_dev_reset_n)
        fmt_q = i_fmt_sel;
    // positions outside the word are skipped, short words stay left aligned
    function automatic logic [23:0] pick(input logic [63:0] b, input int cnt);
        logic [23:0] w;
        int wl;
        int st;
        w = 24'h000000;
        wl = (fmt_q < sar_pkg::FMT_RJ24) ? 16 + 2 * fmt_q : 24;
        st = (fmt_q == sar_pkg::FMT_I2S) ? 1 : (fmt_q == sar_pkg::FMT_LJ) ? 0 : cnt - wl;
        for (int j = 0; j < wl; j++)
            if (st + j >= 0 && st + j < cnt)
                w[23 - j] = b[st + j];
        return w;
    endfunction
    always @(posedge i_link.bclk)
    begin
        if (i_link.lrclk !== lr_last)
        begin
            if (!i_dev_reset_n || !i_arm || o_done)
                got_left = 1'b0;
            else if (lr_last ^ (fmt_q == sar_pkg::FMT_I2S))
            begin
                o_main_l = pick(main_b, n);
                o_sub_l = pick(sub_b, n);
                n_left = n;
                got_left = 1'b1;
            end
            else if (got_left)
            begin
                o_main_r = pick(main_b, n);
                o_bits = 7'(n_left + n);
                o_done = 1'b1;
            end
            n = 0;
            lr_last = i_link.lrclk;
        end
        main_b[n[5:0]] = i_link.main_serial_input;
        sub_b[n[5:0]] = i_link.sub_serial_input;
        n = n + 1;
    end
    always @(negedge i_arm)
        o_done = 1'b0;
    always @(negedge i_back_end_error_n)
        t_fall = $realtime;
    // only pulses long enough to be seen are counted
    always @(posedge i_back_end_error_n)
        if ($realtime - t_fall >= 350.0)
            o_err_cnt = o_err_cnt + 8'h01;
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    typedef struct {
        string name;
        logic [31:0] val;
        logic [31:0] mask;
    } sar_note_type;
    logic I_CLK = 1'b0;
    logic I_RST = 1'b1;
    logic [3:0] I_ADDR = 4'h0;
    logic [31:0] I_WDATA = 32'h0;
    logic I_WR = 1'b0;
    logic I_RD = 1'b0;
    logic [31:0] O_RDATA;
    sar_pkg::sar_link_type O_LINK;
    logic [2:0] O_FMT_SEL;
    logic O_DEV_RESET_N, O_BACK_END_ERROR_N;
    logic arm = 1'b0;
    logic rd_d = 1'b0;
    logic done;
    logic [23:0] m_l, m_r, s_l;
    logic [6:0] bits;
    logic [7:0] errs;
    logic [23:0] smp [4];
    logic [5:0] tests [8] = '{6'h02, 6'h0A, 6'h12, 6'h19, 6'h26, 6'h21, 6'h2E, 6'h28};
    sar_note_type rq[$], fq[$];
    int n_fail = 0;
    int n_checks = 0;
    always #50 I_CLK = ~I_CLK;
    sar_host #(.RECOVER_CYCLES(50), .BCLK_HALF(4)) dut_u (
        .I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
        .I_RD(I_RD), .O_RDATA(O_RDATA), .O_LINK(O_LINK), .O_FMT_SEL(O_FMT_SEL),
        .O_DEV_RESET_N(O_DEV_RESET_N), .O_BACK_END_ERROR_N(O_BACK_END_ERROR_N));
    sar_dev_model dev_u (
        .i_link(O_LINK), .i_fmt_sel(O_FMT_SEL), .i_dev_reset_n(O_DEV_RESET_N),
        .i_back_end_error_n(O_BACK_END_ERROR_N), .i_arm(arm), .o_done(done),
        .o_main_l(m_l), .o_main_r(m_r), .o_sub_l(s_l), .o_bits(bits), .o_err_cnt(errs));
    task automatic check(input sar_note_type e, input logic [31:0] got);
        n_checks++;
        if (e.mask === 32'h0 || (got & e.mask) !== (e.val & e.mask))
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", e.name, e.val, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge I_CLK);
        I_WR <= 1'b1;
        I_ADDR <= a;
        I_WDATA <= d;
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m,
        input string nm);
        rq.push_back('{nm, e, m});
        @(posedge I_CLK);
        I_RD <= 1'b1;
        I_ADDR <= a;
        @(posedge I_CLK);
        I_RD <= 1'b0;
    endtask
    // the model answers with the first whole frame after arming
    task automatic grab(input int nb);
        int k;
        fq.push_back('{"main_left", {8'h00, smp[0]}, 32'hFFFFFF});
        fq.push_back('{"main_right", {8'h00, smp[1]}, 32'hFFFFFF});
        fq.push_back('{"sub_left", {8'h00, smp[2]}, 32'hFFFFFF});
        fq.push_back('{"bits_per_frame", 32'(nb), 32'h7F});
        arm <= 1'b1;
        for (k = 0; k < 3000 && done !== 1'b1; k++)
            @(posedge I_CLK);
        if (done !== 1'b1)
        begin
            n_fail++;
            fq.delete();
            $display("wrong value frame_done expected 1 seen 0");
        end
        arm <= 1'b0;
        @(posedge I_CLK);
    endtask
    task automatic run_fmt(input logic [5:0] t);
        int wl;
        int k;
        wl = (t[5:3] < sar_pkg::FMT_RJ24) ? 16 + 2 * t[5:3] : 24;
        if (t[5:3] > sar_pkg::FMT_RJ24 && !t[2])
            wl = 16;
        wr(sar_pkg::ADDR_CTRL, {25'h0, t, 1'b0});
        for (k = 0; k < 4; k++)
        begin
            smp[k] = 24'($urandom()) & (24'hFFFFFF << (24 - wl));
            wr(4'(sar_pkg::ADDR_MAIN_L + k), {8'h00, smp[k]});
        end
        wr(sar_pkg::ADDR_CTRL, {25'h0, t, 1'b1});
        for (k = 0; k < 1500 && O_DEV_RESET_N !== 1'b1; k++)
            @(posedge I_CLK);
        rd(sar_pkg::ADDR_STAT, 32'h1, 32'h1, "dev_released");
        grab(32 + 16 * t[1:0]);
        $display("test format %0d ratio %0d done", t[5:3], t[1:0]);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge I_CLK)
    begin
        if (rd_d)
            check(rq.pop_front(), O_RDATA);
        rd_d <= I_RD;
    end
    always @(posedge done)
    begin
        check(fq.pop_front(), {8'h00, m_l});
        check(fq.pop_front(), {8'h00, m_r});
        check(fq.pop_front(), {8'h00, s_l});
        check(fq.pop_front(), {25'h0, bits});
    end
    initial
    begin
        void'($urandom(32'h6841));
        repeat (20) @(posedge I_CLK);
        I_RST <= 1'b0;
        rd(sar_pkg::ADDR_CTRL, 32'h4, 32'h7F, "ctrl_reset");
        wr(sar_pkg::ADDR_CTRL, 32'h76);
        rd(sar_pkg::ADDR_CTRL, 32'h4, 32'h7F, "ctrl_ratio_fmt_refused");
        rd(4'h3, 32'h0, 32'hFFFFFFFF, "unmapped");
        rd(sar_pkg::ADDR_STAT, 32'h0, 32'h7, "stat_reset");
        $display("test registers done");
        for (int i = 0; i < 8; i++)
        begin
            run_fmt(tests[i]);
            if (i == 4)
            begin
                // pins stay frozen, so the device keeps decoding the old framing
                wr(sar_pkg::ADDR_CTRL, {25'h0, 6'h2E, 1'b1});
                grab(64);
            end
        end
        wr(sar_pkg::ADDR_ERR, 32'h1);
        rd(sar_pkg::ADDR_STAT, 32'h2, 32'h6, "stat_pulse");
        wr(sar_pkg::ADDR_ERR, 32'h1);
        repeat (8) @(posedge I_CLK);
        rd(sar_pkg::ADDR_STAT, 32'h4, 32'h6, "stat_hold");
        wr(sar_pkg::ADDR_ERR, 32'h1);
        repeat (60) @(posedge I_CLK);
        rd(sar_pkg::ADDR_STAT, 32'h0, 32'h6, "stat_idle");
        check('{"error_pulses", 32'h1, 32'hFF}, {24'h0, errs});
        wr(sar_pkg::ADDR_ERR, 32'h1);
        repeat (10) @(posedge I_CLK);
        check('{"error_pulses", 32'h2, 32'hFF}, {24'h0, errs});
        $display("test back end error done");
        complete_run();
    end
    initial
    begin
        #(40000 * 100);
        n_fail++;
        $display("wrong value watchdog expected finish seen timeout");
        complete_run();
    end
endmodule
bind sar_host sar_host_sva #(.RECOVER_CYCLES(RECOVER_CYCLES), .BCLK_HALF(BCLK_HALF)) chk_u (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .I_RD(I_RD), .O_RDATA(O_RDATA), .O_LINK(O_LINK), .O_FMT_SEL(O_FMT_SEL),
    .O_DEV_RESET_N(O_DEV_RESET_N), .O_BACK_END_ERROR_N(O_BACK_END_ERROR_N));
